// ---- hdl/fep_pkg.sv ----
`default_nettype none
package fep_pkg;
	// ************************************************************
	// Opcodes
	// ************************************************************
	localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
	localparam logic [7:0] OP_DEEP_PD = 8'hB9;
	localparam logic [7:0] OP_RELEASE_ID = 8'hAB;
	localparam logic [7:0] OP_ID_1 = 8'h90;
	localparam logic [7:0] OP_ID_2 = 8'h92;
	localparam logic [7:0] OP_ID_4 = 8'h94;

	// ************************************************************
	// Frame layout
	// ************************************************************
	localparam logic [5:0] CMD_CLKS = 6'h08;
	localparam logic [5:0] ADDR_END_CLKS = 6'h20;
	localparam logic [5:0] CNT_MAX = 6'h3F;
	localparam logic [2:0] BYTE_LSB_MASK = 3'h7;
	localparam int BLK_MSB = 23;
	localparam int BLK_LSB = 16;
	localparam logic [8:0] NUM_BLOCKS = 9'h100;
	localparam logic [4:0] BP_NONE = 5'h00;
	localparam logic [22:0] ID_ADDR_HI = 23'h00_0000;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_MHZ = 25;
	localparam int T_BLOCK_ERASE_US = 500_000;
	localparam int T_CHIP_ERASE_US = 30_000_000;
	localparam int T_PD_ENTRY_US = 3;
	localparam int T_RELEASE_US = 20;
	localparam int BLOCK_ERASE_CYC = T_BLOCK_ERASE_US * CLK_MHZ;
	localparam int CHIP_ERASE_CYC = T_CHIP_ERASE_US * CLK_MHZ;
	localparam int PD_ENTRY_CYC = T_PD_ENTRY_US * CLK_MHZ;
	localparam int RELEASE_CYC = T_RELEASE_US * CLK_MHZ;
	localparam logic [2:0] SCLK_HALF = 3'h4;
	localparam logic [31:0] CS_GAP_CYC = 32'h0000_0002;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_ERASE    = 3'b001,
		ST_DP_ENTRY = 3'b010,
		ST_DPD      = 3'b011,
		ST_RECOVER  = 3'b100
	} fep_dev_st_t;

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_XFER = 2'b01,
		H_GAP  = 2'b10
	} fep_host_st_t;

	// Data lines used after the opcode
	function automatic logic [2:0] fep_lanes(input logic [7:0] op);
		case (op)
			OP_ID_2: fep_lanes = 3'h2;
			OP_ID_4: fep_lanes = 3'h4;
			default: fep_lanes = 3'h1;
		endcase
	endfunction

	// Clocks of opcode plus address or dummy bytes
	function automatic logic [5:0] fep_hdr_clks(input logic [7:0] op);
		case (op)
			OP_BLOCK_ERASE, OP_ID_1, OP_RELEASE_ID: fep_hdr_clks = 6'h20;
			OP_ID_2: fep_hdr_clks = 6'h14;
			OP_ID_4: fep_hdr_clks = 6'h0E;
			default: fep_hdr_clks = 6'h08;
		endcase
	endfunction
endpackage
`default_nettype wire

// ---- hdl/fep_if.sv ----
`default_nettype none
interface fep_if;
	logic       cs_n;
	logic       sclk;
	logic [3:0] host_io_o;
	logic [3:0] host_io_oe;
	logic [3:0] dev_io_o;
	logic [3:0] dev_io_oe;
	logic [3:0] io;

	// Resolved line level, pulled high when nobody drives
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			io[i] = dev_io_oe[i] ? dev_io_o[i] : (host_io_oe[i] ? host_io_o[i] : 1'b1);
		end
	end

	modport host (output cs_n, output sclk, output host_io_o, output host_io_oe, input io);
	modport dev (input cs_n, input sclk, input io, output dev_io_o, output dev_io_oe);
endinterface
`default_nettype wire

// ---- hdl/fep_sync.sv ----
`default_nettype none
module fep_sync #(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} fep_sync_t;

	fep_sync_t r_q;
	fep_sync_t r_d;

	always_comb begin
		r_d.meta = d_i;
		r_d.q = r_q.meta;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_q <= {RST, RST};
		end else begin
			r_q <= r_d;
		end
	end

	assign q_o = r_q.q;
endmodule
`default_nettype wire

// ---- hdl/fep_dev.sv ----
`default_nettype none
// Functional notes
// [R1] D8 plus address erases whole 64KB block
// [R2] Erase refused unless write enable latch set
// [R3] Block erase needs select rise after address
// [R4] Block erase timed, in-progress flag while running
// [R5] Erase clears write enable latch
// [R6] Protected block is not erased
// [R7] 60 or C7 alone means chip erase
// [R8] Chip erase timed, in-progress flag held
// [R9] Chip erase only with all protection zero
// [R10] B9 alone enters deep power-down after delay
// [R11] In power-down only AB is honoured
// [R12] Power-down refused while a cycle runs
// [R13] Deselect gives standby; reset starts standby
// [R14] After release, nothing accepted until recovery
// [R15] AB plus three dummies streams device byte
// [R16] AB ignored while a cycle runs
// [R17] 90 at address zero: maker then device
// [R18] Address one gives device byte first
// [R19] 92 reads identity on two lines
// [R20] 94 reads identity on four lines
// [R21] Identity bytes keep alternating while selected
module fep_dev #(
	parameter logic [7:0] MAKER_ID  = 8'h5A, // Arbitrary value
	parameter logic [7:0] DEVICE_ID = 8'h3C, // Arbitrary value
	parameter int         BE_CYC    = fep_pkg::BLOCK_ERASE_CYC,
	parameter int         CE_CYC    = fep_pkg::CHIP_ERASE_CYC,
	parameter int         DP_CYC    = fep_pkg::PD_ENTRY_CYC,
	parameter int         RES_CYC   = fep_pkg::RELEASE_CYC
) (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic       wel_set_i,
	input  wire logic [4:0] block_prot_i,
	output logic            wel_o,
	output logic            wip_o,
	output logic            deep_pd_o,
	output logic            erase_start_o,
	output logic            erase_chip_o,
	output logic [7:0]      erase_block_o,
	fep_if.dev              bus
);
	// ************************************************************
	// Link side: command capture on rising serial clock
	// ************************************************************
	typedef struct packed {
		logic [5:0]  cnt;
		logic [7:0]  opc;
		logic [23:0] addr;
		logic        tx;
	} fep_rx_t;

	typedef struct packed {
		logic       act;
		logic       sel_dev;
		logic [7:0] sh;
		logic [3:0] left;
		logic [3:0] out;
		logic [3:0] oe;
	} fep_tx_t;

	typedef struct packed {
		fep_pkg::fep_dev_st_t st;
		logic [31:0]          tmr;
		logic                 cs_d;
		logic                 write_enable_latch;
		logic                 write_in_progress_flag;
		logic                 lvl_idle;
		logic                 lvl_dpd;
		logic                 start;
		logic                 chip;
		logic [7:0]           blk;
	} fep_sys_t;

	fep_rx_t  rx_q;
	fep_rx_t  rx_d;
	fep_tx_t  tx_q;
	fep_tx_t  tx_d;
	fep_sys_t s_q;
	fep_sys_t s_d;
	logic     first_q;
	logic [1:0] lvl_s;
	logic     cs_s;
	logic [5:0] cur_cnt;
	logic [2:0] rx_lanes;
	logic [2:0] tx_lanes;
	logic [7:0] next_byte;
	logic     rise;
	logic     prot_hit;
	logic     wel_clr;

	// Frame start marker, set while deselected
	always_ff @(posedge bus.sclk or posedge bus.cs_n) begin
		if (bus.cs_n) begin
			first_q <= 1'b1;
		end else begin
			first_q <= 1'b0;
		end
	end

	fep_sync #(.W(2), .RST(2'b10)) u_lvl_sync (
		.clk_i (bus.sclk),
		.rst_i (1'b0),
		.d_i   ({s_q.lvl_idle, s_q.lvl_dpd}),
		.q_o   (lvl_s)
	);

	assign cur_cnt = first_q ? 6'h00 : rx_q.cnt;
	assign rx_lanes = fep_pkg::fep_lanes(rx_q.opc);

	always_comb begin
		rx_d = rx_q;
		rx_d.tx = first_q ? 1'b0 : rx_q.tx;
		rx_d.cnt = (cur_cnt == fep_pkg::CNT_MAX) ? cur_cnt : cur_cnt + 6'h01;
		if (cur_cnt < fep_pkg::CMD_CLKS) begin
			rx_d.opc = {rx_q.opc[6:0], bus.io[0]};
		end else if (cur_cnt < fep_pkg::fep_hdr_clks(rx_q.opc)) begin
			case (rx_lanes)
				3'h2: rx_d.addr = {rx_q.addr[21:0], bus.io[1:0]}; // R19
				3'h4: rx_d.addr = {rx_q.addr[19:0], bus.io[3:0]}; // R20
				default: rx_d.addr = {rx_q.addr[22:0], bus.io[0]};
			endcase
			if (rx_d.cnt == fep_pkg::fep_hdr_clks(rx_q.opc)) begin
				case (rx_q.opc)
					fep_pkg::OP_RELEASE_ID: begin
						rx_d.tx = lvl_s[1] | lvl_s[0]; // R15 R16
					end
					fep_pkg::OP_ID_1, fep_pkg::OP_ID_2, fep_pkg::OP_ID_4: begin
						rx_d.tx = lvl_s[1] && (rx_d.addr[23:1] == fep_pkg::ID_ADDR_HI); // R11 R17
					end
					default: rx_d.tx = 1'b0;
				endcase
			end
		end
	end

	always_ff @(posedge bus.sclk) begin
		rx_q <= rx_d;
	end

	// ************************************************************
	// Link side: identity output on falling serial clock
	// ************************************************************
	assign tx_lanes = fep_pkg::fep_lanes(rx_q.opc);

	always_comb begin
		tx_d = tx_q;
		next_byte = (rx_q.opc == fep_pkg::OP_RELEASE_ID || tx_d.sel_dev) ? DEVICE_ID : MAKER_ID;
		if (rx_q.tx) begin
			if (!tx_q.act) begin
				tx_d.sel_dev = rx_q.addr[0]; // R18
				next_byte = (rx_q.opc == fep_pkg::OP_RELEASE_ID || rx_q.addr[0]) ?
					DEVICE_ID : MAKER_ID;
			end
			tx_d.act = 1'b1;
			if (tx_q.left == 4'h0) begin
				tx_d.sh = next_byte << tx_lanes;
				tx_d.left = 4'h8 - 4'(tx_lanes);
				tx_d.sel_dev = ~tx_d.sel_dev; // R21
				tx_d.out = place(next_byte, tx_lanes); // R15 R17
			end else begin
				tx_d.out = place(tx_q.sh, tx_lanes);
				tx_d.sh = tx_q.sh << tx_lanes;
				tx_d.left = tx_q.left - 4'(tx_lanes);
			end
			case (tx_lanes)
				3'h2: tx_d.oe = 4'b0011;
				3'h4: tx_d.oe = 4'b1111;
				default: tx_d.oe = 4'b0010;
			endcase
		end
	end

	always_ff @(negedge bus.sclk or posedge bus.cs_n) begin
		if (bus.cs_n) begin
			tx_q <= '0;
		end else begin
			tx_q <= tx_d;
		end
	end

	assign bus.dev_io_o = tx_q.out;
	assign bus.dev_io_oe = tx_q.oe;

	// ************************************************************
	// System side: execution at deselect, self-timed cycles
	// ************************************************************
	fep_sync #(.W(1), .RST(1'b1)) u_cs_sync (
		.clk_i (clk_sys_i),
		.rst_i (rst_i),
		.d_i   (bus.cs_n),
		.q_o   (cs_s)
	);

	// Frame registers are read only after the select rise has crossed, while the
	// serial clock is stopped, so they stand still when sampled here.
	assign rise = cs_s & ~s_q.cs_d;

	always_comb begin
		prot_hit = blk_locked(block_prot_i, rx_q.addr[fep_pkg::BLK_MSB:fep_pkg::BLK_LSB]);
	end

	always_comb begin
		s_d = s_q;
		s_d.cs_d = cs_s;
		s_d.start = 1'b0;
		wel_clr = 1'b0;
		if (s_q.tmr != 32'h0000_0000) begin
			s_d.tmr = s_q.tmr - 32'h0000_0001;
		end
		case (s_q.st)
			fep_pkg::ST_IDLE: begin
				if (rise) begin
					if (rx_q.opc == fep_pkg::OP_BLOCK_ERASE && // R1
						rx_q.cnt == fep_pkg::ADDR_END_CLKS && // R3
						s_q.write_enable_latch && !prot_hit) begin // R2 R6
						s_d.st = fep_pkg::ST_ERASE;
						s_d.tmr = 32'(BE_CYC - 1); // R4
						s_d.chip = 1'b0;
						s_d.blk = rx_q.addr[fep_pkg::BLK_MSB:fep_pkg::BLK_LSB]; // R1
						s_d.start = 1'b1;
					end else if ((rx_q.opc == fep_pkg::OP_CHIP_ERASE_A ||
						rx_q.opc == fep_pkg::OP_CHIP_ERASE_B) && // R7
						rx_q.cnt == fep_pkg::CMD_CLKS && s_q.write_enable_latch && // R2 R7
						block_prot_i == fep_pkg::BP_NONE) begin // R9
						s_d.st = fep_pkg::ST_ERASE;
						s_d.tmr = 32'(CE_CYC - 1); // R8
						s_d.chip = 1'b1;
						s_d.start = 1'b1;
					end else if (rx_q.opc == fep_pkg::OP_DEEP_PD &&
						rx_q.cnt == fep_pkg::CMD_CLKS) begin // R10
						s_d.st = fep_pkg::ST_DP_ENTRY;
						s_d.tmr = 32'(DP_CYC - 1); // R10
					end
				end
			end
			fep_pkg::ST_ERASE: begin
				// Every command is dropped while busy
				wel_clr = 1'b1; // R5
				if (s_q.tmr == 32'h0000_0000) begin // R12 R16
					s_d.st = fep_pkg::ST_IDLE; // R4 R8 R13
				end
			end
			fep_pkg::ST_DP_ENTRY: begin
				if (s_q.tmr == 32'h0000_0000) begin
					s_d.st = fep_pkg::ST_DPD; // R10
				end
			end
			fep_pkg::ST_DPD: begin
				if (rise && rx_q.opc == fep_pkg::OP_RELEASE_ID &&
					rx_q.cnt >= fep_pkg::CMD_CLKS) begin // R11
					s_d.st = fep_pkg::ST_RECOVER;
					s_d.tmr = 32'(RES_CYC - 1); // R14
				end
			end
			fep_pkg::ST_RECOVER: begin
				if (s_q.tmr == 32'h0000_0000) begin
					s_d.st = fep_pkg::ST_IDLE; // R14
				end
			end
			default: begin
				s_d.st = fep_pkg::ST_IDLE;
			end
		endcase
		// Set is taken only in idle, so a clear during erase always wins
		if (wel_set_i && s_q.st == fep_pkg::ST_IDLE) begin // R11
			s_d.write_enable_latch = 1'b1;
		end else if (wel_clr) begin
			s_d.write_enable_latch = 1'b0; // R5
		end
		s_d.write_in_progress_flag = (s_d.st == fep_pkg::ST_ERASE); // R4 R8
		s_d.lvl_idle = (s_d.st == fep_pkg::ST_IDLE);
		s_d.lvl_dpd = (s_d.st == fep_pkg::ST_DPD);
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			s_q <= '{st: fep_pkg::ST_IDLE, tmr: 32'h0000_0000, cs_d: 1'b1, write_enable_latch: 1'b0,
				write_in_progress_flag: 1'b0, lvl_idle: 1'b1, lvl_dpd: 1'b0, start: 1'b0,
				chip: 1'b0, blk: 8'h00}; // R13
		end else begin
			s_q <= s_d;
		end
	end

	assign wel_o = s_q.write_enable_latch;
	assign wip_o = s_q.write_in_progress_flag;
	assign deep_pd_o = s_q.lvl_dpd;
	assign erase_start_o = s_q.start;
	assign erase_chip_o = s_q.chip;
	assign erase_block_o = s_q.blk;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [3:0] place(input logic [7:0] v, input logic [2:0] l);
		case (l)
			3'h2: place = {2'b00, v[7:6]};
			3'h4: place = v[7:4];
			default: place = {2'b00, v[7], 1'b0};
		endcase
	endfunction

	// Top or bottom span of 2^(n-1) blocks; bit 4 guards all
	function automatic logic blk_locked(input logic [4:0] bp, input logic [7:0] blk);
		logic [8:0] span;
		span = 9'h001 << (bp[2:0] - 3'h1);
		if (bp[4]) begin
			blk_locked = 1'b1;
		end else if (bp[2:0] == 3'h0) begin
			blk_locked = 1'b0;
		end else if (bp[3]) begin
			blk_locked = {1'b0, blk} < span;
		end else begin
			blk_locked = {1'b0, blk} >= (fep_pkg::NUM_BLOCKS - span);
		end
	endfunction
endmodule
`default_nettype wire

// ---- hdl/fep_host.sv ----
`default_nettype none
module fep_host #(
	parameter int RES_CYC = fep_pkg::RELEASE_CYC
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        cmd_valid_i,
	output logic             cmd_ready_o,
	input  wire logic [7:0]  cmd_op_i,
	input  wire logic [23:0] cmd_addr_i,
	input  wire logic [3:0]  cmd_rx_len_i,
	output logic [7:0]       rx_data_o,
	output logic             rx_valid_o,
	fep_if.host              bus
);
	typedef struct packed {
		fep_pkg::fep_host_st_t st;
		logic [2:0]  div;
		logic        sclk;
		logic        cs_n;
		logic [7:0]  idx;
		logic [7:0]  tx_clks;
		logic [7:0]  total;
		logic [2:0]  lanes;
		logic [31:0] txsh;
		logic [3:0]  io_o;
		logic [3:0]  oe;
		logic [7:0]  rxsh;
		logic [3:0]  rxbits;
		logic [7:0]  rxd;
		logic        rxv;
		logic [31:0] wait_c;
	} fep_host_r_t;

	fep_host_r_t r_q;
	fep_host_r_t r_d;
	logic [3:0]  io_s;
	logic [6:0]  rx_bits;
	logic [7:0]  hdr;
	logic [2:0]  lc;
	// Opcode of the frame in flight, kept for the deselect gap
	logic [7:0]  bus_op_q;

	fep_sync #(.W(4), .RST(4'hF)) u_io_sync (
		.clk_i (clk_sys_i),
		.rst_i (rst_i),
		.d_i   (bus.io),
		.q_o   (io_s)
	);

	// ************************************************************
	// Frame engine, serial clock divided from system clock
	// ************************************************************
	always_comb begin
		r_d = r_q;
		r_d.rxv = 1'b0;
		rx_bits = {cmd_rx_len_i, 3'b000};
		hdr = {2'b00, fep_pkg::fep_hdr_clks(cmd_op_i)};
		lc = (r_q.idx < {2'b00, fep_pkg::CMD_CLKS}) ? 3'h1 : r_q.lanes;
		case (r_q.st)
			fep_pkg::H_IDLE: begin
				if (cmd_valid_i) begin
					r_d.st = fep_pkg::H_XFER;
					r_d.lanes = fep_pkg::fep_lanes(cmd_op_i);
					// Release without read stops right after the opcode
					if (cmd_op_i == fep_pkg::OP_RELEASE_ID && cmd_rx_len_i == 4'h0) begin
						hdr = {2'b00, fep_pkg::CMD_CLKS}; // R14
					end
					r_d.tx_clks = hdr;
					case (fep_pkg::fep_lanes(cmd_op_i))
						3'h2: r_d.total = hdr + {2'b00, rx_bits[6:1]};
						3'h4: r_d.total = hdr + {3'b000, rx_bits[6:2]};
						default: r_d.total = hdr + {1'b0, rx_bits};
					endcase
					r_d.txsh = {cmd_op_i[6:0], cmd_addr_i, 1'b0};
					r_d.io_o = {3'b000, cmd_op_i[7]};
					r_d.oe = 4'b0001;
					r_d.cs_n = 1'b0;
					r_d.sclk = 1'b0;
					r_d.div = 3'h0;
					r_d.idx = 8'h00;
					r_d.rxbits = 4'h0;
				end
			end
			fep_pkg::H_XFER: begin
				r_d.div = r_q.div + 3'h1;
				if (r_q.div == fep_pkg::SCLK_HALF - 3'h1) begin
					r_d.div = 3'h0;
					if (!r_q.sclk) begin
						r_d.sclk = 1'b1;
						r_d.idx = r_q.idx + 8'h01;
						if (r_q.idx >= r_q.tx_clks) begin
							case (r_q.lanes)
								3'h2: r_d.rxsh = {r_q.rxsh[5:0], io_s[1:0]};
								3'h4: r_d.rxsh = {r_q.rxsh[3:0], io_s[3:0]};
								default: r_d.rxsh = {r_q.rxsh[6:0], io_s[1]};
							endcase
							r_d.rxbits = r_q.rxbits + 4'(r_q.lanes);
							if (r_d.rxbits == 4'h8) begin
								r_d.rxbits = 4'h0;
								r_d.rxd = r_d.rxsh;
								r_d.rxv = 1'b1;
							end
						end
					end else begin
						r_d.sclk = 1'b0;
						if (r_q.idx == r_q.total) begin
							// Select rises on the byte boundary
							r_d.cs_n = 1'b1; // R3 R7
							r_d.oe = 4'b0000;
							r_d.st = fep_pkg::H_GAP;
							r_d.wait_c = (bus_op_q == fep_pkg::OP_RELEASE_ID) ?
								32'(RES_CYC) : fep_pkg::CS_GAP_CYC; // R14
						end else if (r_q.idx < r_q.tx_clks) begin
							case (lc)
								3'h2: r_d.io_o = {2'b00, r_q.txsh[31:30]};
								3'h4: r_d.io_o = r_q.txsh[31:28];
								default: r_d.io_o = {3'b000, r_q.txsh[31]};
							endcase
							r_d.oe = (lc == 3'h4) ? 4'b1111 : ((lc == 3'h2) ? 4'b0011 : 4'b0001);
							r_d.txsh = r_q.txsh << lc;
						end else begin
							r_d.oe = 4'b0000;
						end
					end
				end
			end
			fep_pkg::H_GAP: begin
				if (r_q.wait_c == 32'h0000_0000) begin
					r_d.st = fep_pkg::H_IDLE;
				end else begin
					r_d.wait_c = r_q.wait_c - 32'h0000_0001;
				end
			end
			default: begin
				r_d.st = fep_pkg::H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			bus_op_q <= 8'h00;
		end else if (r_q.st == fep_pkg::H_IDLE && cmd_valid_i) begin
			bus_op_q <= cmd_op_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			r_q <= '0;
			r_q.cs_n <= 1'b1;
			r_q.st <= fep_pkg::H_IDLE;
		end else begin
			r_q <= r_d;
		end
	end

	assign cmd_ready_o = (r_q.st == fep_pkg::H_IDLE);
	assign rx_data_o = r_q.rxd;
	assign rx_valid_o = r_q.rxv;
	assign bus.cs_n = r_q.cs_n;
	assign bus.sclk = r_q.sclk;
	assign bus.host_io_o = r_q.io_o;
	assign bus.host_io_oe = r_q.oe;
endmodule
`default_nettype wire

// ---- verif/fep_assertions.sv ----
`default_nettype none
module fep_assertions #(
	parameter int RES_CYC = 20
) (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic       cs_n,
	input  wire logic       sclk,
	input  wire logic [3:0] host_io_o,
	input  wire logic [3:0] host_io_oe,
	input  wire logic [3:0] dev_io_o,
	input  wire logic [3:0] dev_io_oe,
	input  wire logic [3:0] io
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        sclk_q;
	logic [7:0]  edges_q;
	logic [7:0]  op_q;
	logic [15:0] gap_q;
	logic [3:0]  lanes;
	logic [7:0]  hdr;

	// ********
	// Frame tracking
	// ********
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sclk_q  <= 1'b0;
			edges_q <= 8'h00;
			op_q    <= 8'h00;
			gap_q   <= 16'h0000;
		end else begin
			sclk_q <= sclk;
			if (cs_n) begin
				edges_q <= 8'h00;
				gap_q   <= gap_q + {15'h0000, gap_q != 16'hFFFF};
			end else begin
				gap_q <= 16'h0000;
				if (sclk && !sclk_q) begin
					edges_q <= edges_q + 8'h01;
					if (edges_q < 8'h08)
						op_q <= {op_q[6:0], io[0]};
				end
			end
		end
	end
	assign lanes = (op_q == fep_pkg::OP_ID_4) ? 4'hF : (op_q == fep_pkg::OP_ID_2) ? 4'h3 : 4'h2;
	assign hdr = (op_q == fep_pkg::OP_ID_4) ? 8'h0E : (op_q == fep_pkg::OP_ID_2) ? 8'h14 : 8'h20;

	// ********
	// Properties
	// ********
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	property p_quiet; cs_n |-> dev_io_oe == 4'h0; endproperty
	a_quiet: assert property (p_quiet) else $error("device drives while deselected");
	property p_fall; dev_io_oe != 4'h0 && $stable(dev_io_oe) && $changed(dev_io_o & dev_io_oe) |-> $fell(sclk); endproperty
	a_fall: assert property (p_fall) else $error("device data moved off a falling edge");
	property p_fight; (host_io_oe & dev_io_oe) == 4'h0; endproperty
	a_fight: assert property (p_fight) else $error("both ends drive one line");
	property p_sclk; cs_n && $past(cs_n) |-> $stable(sclk); endproperty
	a_sclk: assert property (p_sclk) else $error("serial clock moved while deselected");
	property p_start; $rose(|dev_io_oe) |-> edges_q == hdr; endproperty
	a_start: assert property (p_start) else $error("reply began at wrong clock count");
	property p_lanes; dev_io_oe != 4'h0 |-> dev_io_oe == lanes; endproperty
	a_lanes: assert property (p_lanes) else $error("reply on wrong lines");
	property p_bytes; $rose(cs_n) && lanes == 4'h2 |-> edges_q[2:0] == 3'h0; endproperty
	a_bytes: assert property (p_bytes) else $error("select rose off a byte boundary");
	property p_recov; $fell(cs_n) && op_q == fep_pkg::OP_RELEASE_ID |-> gap_q >= RES_CYC; endproperty
	a_recov: assert property (p_recov) else $error("select fell inside recovery");
	c_dual: cover property (dev_io_oe == 4'h3);
	c_quad: cover property (dev_io_oe == 4'hF);
	c_erase: cover property ($rose(cs_n) && op_q == fep_pkg::OP_BLOCK_ERASE);
	c_release: cover property ($fell(cs_n) && op_q == fep_pkg::OP_RELEASE_ID);
endmodule
`default_nettype wire

// ---- verif/tb_flash_erase_powerdown_id.sv ----
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; \
	if ((ex) !== (got)) begin n_fail++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_flash_erase_powerdown_id;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] MK = 8'h5A; // Arbitrary value
	localparam logic [7:0] DV = 8'h3C; // Arbitrary value
	localparam int         BE = 2000;
	localparam int         CE = 3000;
	localparam int         DP = 30;
	localparam int         RC = 20;
	logic        clk_sys_i    = 1'b0;
	logic        rst_i        = 1'b1;
	logic        wel_set_i    = 1'b0;
	logic [4:0]  block_prot_i = 5'h00;
	logic        cmd_valid_i  = 1'b0;
	logic [7:0]  cmd_op_i     = 8'h00;
	logic [23:0] cmd_addr_i   = 24'h00_0000;
	logic [3:0]  cmd_rx_len_i = 4'h0;
	logic        cmd_ready_o;
	logic        rx_valid_o;
	logic [7:0]  rx_data_o;
	logic        wel_o;
	logic        wip_o;
	logic        deep_pd_o;
	logic        erase_start_o;
	logic        erase_chip_o;
	logic [7:0]  erase_block_o;
	int          n_fail      = 0;
	int          check_count = 0;
	int          starts      = 0;
	int          wip_len     = 0;
	logic [7:0]  rxq[$];

	fep_if bus_if ();
	fep_host #(.RES_CYC(RC)) fep_host_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i),
		.cmd_addr_i(cmd_addr_i), .cmd_rx_len_i(cmd_rx_len_i), .rx_data_o(rx_data_o),
		.rx_valid_o(rx_valid_o), .bus(bus_if));
	fep_dev #(.MAKER_ID(MK), .DEVICE_ID(DV), .BE_CYC(BE), .CE_CYC(CE), .DP_CYC(DP),
		.RES_CYC(RC)) fep_dev_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wel_set_i(wel_set_i),
		.block_prot_i(block_prot_i), .wel_o(wel_o), .wip_o(wip_o), .deep_pd_o(deep_pd_o),
		.erase_start_o(erase_start_o), .erase_chip_o(erase_chip_o),
		.erase_block_o(erase_block_o), .bus(bus_if));
	fep_assertions #(.RES_CYC(RC)) fep_assertions_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.cs_n(bus_if.cs_n), .sclk(bus_if.sclk), .host_io_o(bus_if.host_io_o),
		.host_io_oe(bus_if.host_io_oe), .dev_io_o(bus_if.dev_io_o),
		.dev_io_oe(bus_if.dev_io_oe), .io(bus_if.io));

	always #20 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		if (rx_valid_o === 1'b1)
			rxq.push_back(rx_data_o);
		if (erase_start_o === 1'b1)
			starts++;
		if (wip_o === 1'b1)
			wip_len++;
	end

	// ********
	// Drivers
	// ********
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic send(input logic [7:0] op, input logic [23:0] ad, input logic [3:0] n);
		int k;
		cyc(1);
		rxq.delete();
		cmd_op_i = op;
		cmd_addr_i = ad;
		cmd_rx_len_i = n;
		cmd_valid_i = 1'b1;
		for (k = 0; k < 5000 && cmd_ready_o !== 1'b1; k++)
			cyc(1);
		cyc(1);
		cmd_valid_i = 1'b0;
		for (k = 0; k < 5000 && cmd_ready_o !== 1'b1; k++)
			cyc(1);
		cyc(6);
	endtask
	task automatic wel_pulse();
		wel_set_i = 1'b1;
		cyc(1);
		wel_set_i = 1'b0;
		cyc(2);
	endtask
	task automatic wait_idle();
		for (int k = 0; k < 9000 && wip_o !== 1'b0; k++)
			cyc(1);
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_ids();
		logic [7:0] ops[3] = '{fep_pkg::OP_ID_1, fep_pkg::OP_ID_2, fep_pkg::OP_ID_4};
		`CHK("reset", 12'h000, {wel_o, wip_o, deep_pd_o, erase_chip_o, erase_block_o})
		for (int o = 0; o < 3; o++)
			for (int a = 0; a < 2; a++) begin
				send(ops[o], 24'(a), 4'h3);
				`CHK("id_cnt", 3, rxq.size())
				for (int i = 0; i < rxq.size(); i++)
					`CHK("id", ((i + a) % 2) ? DV : MK, rxq[i])
			end
		send(fep_pkg::OP_RELEASE_ID, 24'h00_0000, 4'h3);
		`CHK("dev_id", {DV, DV, DV}, {rxq[0], rxq[1], rxq[2]})
	endtask
	task automatic t_block();
		starts = 0;
		send(fep_pkg::OP_BLOCK_ERASE, 24'h12_3456, 4'h0);
		`CHK("no_wel", 0, starts)
		wel_pulse();
		send(fep_pkg::OP_BLOCK_ERASE, 24'h12_3456, 4'h1);
		`CHK("long", 0, starts)
		block_prot_i = 5'h01;
		wel_pulse();
		send(fep_pkg::OP_BLOCK_ERASE, 24'hFF_0000, 4'h0);
		`CHK("prot", 0, starts)
		wel_pulse();
		wip_len = 0;
		send(fep_pkg::OP_BLOCK_ERASE, 24'h12_3456, 4'h0);
		`CHK("be_run", {1'b1, 8'h12}, {wip_o, erase_block_o})
		send(fep_pkg::OP_RELEASE_ID, 24'h00_0000, 4'h1);
		`CHK("id_busy", 8'hFF, rxq[0])
		send(fep_pkg::OP_DEEP_PD, 24'h00_0000, 4'h0);
		wait_idle();
		`CHK("be_done", 3'b000, {deep_pd_o, wel_o, wip_o})
		`CHK("be_len", 1'b1, wip_len >= BE && wip_len <= BE + 2)
		`CHK("be_once", 1, starts)
	endtask
	task automatic t_chip();
		logic [7:0] op;
		for (int c = 0; c < 2; c++) begin
			op = c ? fep_pkg::OP_CHIP_ERASE_B : fep_pkg::OP_CHIP_ERASE_A;
			starts = 0;
			block_prot_i = 5'h01;
			wel_pulse();
			send(op, 24'h00_0000, 4'h0);
			`CHK("ce_prot", 0, starts)
			block_prot_i = 5'h00;
			wel_pulse();
			send(op, 24'h00_0000, 4'h1);
			`CHK("ce_long", 0, starts)
			wel_pulse();
			wip_len = 0;
			send(op, 24'h00_0000, 4'h0);
			`CHK("ce_run", 2'b11, {wip_o, erase_chip_o})
			wait_idle();
			`CHK("ce_len", 1'b1, wip_len >= CE && wip_len <= CE + 2)
			`CHK("ce_wel", 1'b0, wel_o)
		end
	endtask
	task automatic t_pd();
		send(fep_pkg::OP_DEEP_PD, 24'h00_0000, 4'h1);
		cyc(DP + 4);
		`CHK("pd_long", 1'b0, deep_pd_o)
		wel_pulse();
		send(fep_pkg::OP_DEEP_PD, 24'h00_0000, 4'h0);
		cyc(DP + 4);
		`CHK("pd_on", 1'b1, deep_pd_o)
		send(fep_pkg::OP_CHIP_ERASE_B, 24'h00_0000, 4'h0);
		`CHK("pd_erase", 2'b01, {wip_o, wel_o})
		send(fep_pkg::OP_ID_1, 24'h00_0000, 4'h2);
		`CHK("pd_id", 16'hFFFF, {rxq[0], rxq[1]})
		send(fep_pkg::OP_RELEASE_ID, 24'h00_0000, 4'h2);
		`CHK("release", {1'b0, DV, DV}, {deep_pd_o, rxq[0], rxq[1]})
	endtask

	task automatic wrap_up();
		if (n_fail == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (6) @(negedge clk_sys_i);
		rst_i = 1'b0;
		t_ids();
		t_block();
		t_chip();
		t_pd();
		wrap_up();
	end
	initial begin
		repeat (60000) @(posedge clk_sys_i);
		n_fail++;
		wrap_up();
	end
endmodule
`default_nettype wire
